// ===== shared/pil_defines.svh
/*
  constants of the processor interrupt levels block: codes, offsets,
  field positions, reset values and timing counts.
  assumes a 20 mhz pclk and a 32-bit apb master.
*/
// What this block does
// - zero fraction add gives significance code, double-masked
// - zero divisor fraction gives divide code
// - indirect flag bit 5 gives indirect code
// - more than 8 control words gives specification
// - t bit zero suppressed, one terminated
// - analysis level unmasked, trace 01, monitor 00
// - trace table full or instruction done in monitor mode requests
// - supervisor call copies immediate field, unmaskable
// - supervisor call length code binary 0 1
// - external mask bit 2 holds requests pending
// - masked external requests merge by or
// - external taken after instruction, length code 0
// - external code bit per source, msb first
// - timer request on count 1 to 0 or status word
// - timer mask bit 3, merged, after completion
// - nonzero timer status words written even masked
// - i/o levels masked by bits 4 to 11
// - status words only in initiation sequence
// - 16 ms stall timer restarts per instruction
// - wait and initial load retrigger stall timer
// - emulation microprogram retriggers stall timer
// - stall expiry suppressed when stopped or stepping
`ifndef PIL_DEFINES_SVH
`define PIL_DEFINES_SVH

`define PIL_CODE_SIGNIF     8'h0e
`define PIL_CODE_FPDIV      8'h0f
`define PIL_CODE_INDADR     8'h25
`define PIL_CODE_INDSPEC    8'h26
`define PIL_CODE_T_BIT      4
`define PIL_CODE_TRACE      8'h01
`define PIL_CODE_MONITOR    8'h00
`define PIL_ILC_SVC         2'h1
`define PIL_ILC_ZERO        2'h0
`define PIL_IND_FLAG_BIT    5
`define PIL_IND_MAX         4'h8
`define PIL_TRACE_WORDS     8'h80

`define PIL_PSW_PX_BIT      1
`define PIL_PSW_EXT_BIT     2
`define PIL_PSW_TMR_BIT     3
`define PIL_PSW_IO_LO       4
`define PIL_PSW_SIG_BIT     39

`define PIL_OFS_PSWLO       12'h000
`define PIL_OFS_PSWHI       12'h004
`define PIL_OFS_CTRL        12'h008
`define PIL_OFS_PEND        12'h00c
`define PIL_OFS_EXTCODE     12'h010
`define PIL_OFS_TAKE        12'h014
`define PIL_OFS_STATUS      12'h018

`define PIL_RST_PSW         64'h0000000000000000
`define PIL_STALL_MS        16
`define PIL_CLK_KHZ         20000
`define PIL_STALL_CYC       (`PIL_STALL_MS * `PIL_CLK_KHZ)

`endif

// ===== shared/pil_pkg.sv
/*
  types of the processor interrupt levels block.
  assumes pil_defines.svh is included by the design.
*/
package pil_pkg;
  typedef enum logic [1:0] {pil_idle, pil_run, pil_expired} pil_stall_t;
endpackage : pil_pkg

// ===== design/pil_levels.sv
/*
  processor interrupt levels: program exception coding, analysis,
  supervisor call, external, timer and eight i/o levels, stall check,
  with an apb register slave.
  assumes the execution unit pulses its event inputs for one pclk and
  takes a level only while instr_done_i or iis_start_i is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pil_defines.svh"

module pil_levels
  import pil_pkg::*;
#(
  parameter int unsigned STALL_CYC = `PIL_STALL_CYC,
  parameter int unsigned IO_LVLS   = 8
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fp_addsub_zero_i,
  input  wire logic        fp_div_zero_i,
  input  wire logic        ind_word_i,
  input  wire logic [7:0]  ind_word_data_i,
  input  wire logic        ind_start_i,
  input  wire logic        instr_term_i,
  input  wire logic        trace_write_i,
  input  wire logic        monitor_mode_i,
  input  wire logic        svc_i,
  input  wire logic [7:0]  svc_imm_i,
  input  wire logic [7:0]  ext_req_i,
  input  wire logic        tmr_dec_to_zero_i,
  input  wire logic        tmr_csw_i,
  input  wire logic [31:0] tmr_csw_data_i,
  input  wire logic [7:0]  io_req_i,
  input  wire logic [7:0]  io_relieve_i,
  input  wire logic        instr_start_i,
  input  wire logic        instr_done_i,
  input  wire logic        iis_start_i,
  input  wire logic        wait_i,
  input  wire logic        init_load_i,
  input  wire logic        emul_retrig_i,
  input  wire logic        stopped_i,
  input  wire logic        step_mode_i,
  output logic             prog_exc_o,
  output logic      [7:0]  prog_code_o,
  output logic             ana_req_o,
  output logic      [7:0]  ana_code_o,
  output logic             svc_req_o,
  output logic      [7:0]  svc_code_o,
  output logic      [1:0]  ilc_o,
  output logic             ext_req_o,
  output logic      [7:0]  ext_code_o,
  output logic             tmr_req_o,
  output logic             tmr_csw_we_o,
  output logic      [31:0] tmr_csw_o,
  output logic      [7:0]  io_req_o,
  output logic             io_csw_en_o,
  output logic             mchk_req_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0] program_status_word;
    logic [3:0]  ind_cnt;
    logic [7:0]  trace_cnt;
    logic        prog_exc;
    logic [7:0]  prog_code;
    logic        ana;
    logic [7:0]  ana_code;
    logic        svc;
    logic [7:0]  svc_code;
    logic [1:0]  instruction_length_code;
    logic        ext_p;
    logic [7:0]  ext_code;
    logic        tmr_p;
    logic        csw_we;
    logic [31:0] channel_status_word;
    logic [7:0]  io_p;
    logic [31:0] stall_cnt;
    pil_stall_t  stall;
    logic        mchk;
    logic [31:0] rdata;
  } pil_state_t;

  pil_state_t s_q;
  pil_state_t s_d;

  logic        wr;
  logic        rd;
  logic        take_w;
  logic [5:0]  take_v;
  logic [7:0]  io_take;
  logic        retrig;
  logic [31:0] stall_lim;

  assign wr        = psel & penable & pwrite;
  assign rd        = psel & ~penable & ~pwrite;
  assign take_w    = wr && (paddr == `PIL_OFS_TAKE);
  assign take_v    = take_w ? pwdata[5:0] : 6'h00;
  assign io_take   = take_w ? pwdata[15:8] : 8'h00;
  assign stall_lim = STALL_CYC - 1;
  assign retrig    = instr_start_i | iis_start_i | wait_i | init_load_i
                   | emul_retrig_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    s_d.prog_exc = 1'b0;
    s_d.csw_we   = 1'b0;
    if (ind_start_i)
    begin
      s_d.ind_cnt = 4'h0;
    end
    else if (ind_word_i && s_q.ind_cnt != 4'hf)
    begin
      s_d.ind_cnt = s_q.ind_cnt + 4'h1;
    end
    if (fp_addsub_zero_i && s_q.program_status_word[`PIL_PSW_SIG_BIT]
        && s_q.program_status_word[`PIL_PSW_PX_BIT])
    begin
      s_d.prog_exc  = 1'b1;
      s_d.prog_code = `PIL_CODE_SIGNIF
                    | {3'h0, instr_term_i, 4'h0};
    end
    else if (fp_div_zero_i)
    begin
      s_d.prog_exc  = 1'b1;
      s_d.prog_code = `PIL_CODE_FPDIV | {3'h0, instr_term_i, 4'h0};
    end
    else if (ind_word_i && ind_word_data_i[`PIL_IND_FLAG_BIT])
    begin
      s_d.prog_exc  = 1'b1;
      s_d.prog_code = `PIL_CODE_INDADR | {3'h0, instr_term_i, 4'h0};
    end
    else if (ind_word_i && s_q.ind_cnt >= `PIL_IND_MAX)
    begin
      s_d.prog_exc  = 1'b1;
      s_d.prog_code = `PIL_CODE_INDSPEC | {3'h0, instr_term_i, 4'h0};
    end
    if (trace_write_i)
    begin
      s_d.trace_cnt = s_q.trace_cnt + 8'h01;
    end
    if (take_v[0])
    begin
      s_d.ana = 1'b0;
    end
    if (trace_write_i && s_q.trace_cnt == `PIL_TRACE_WORDS - 8'h01)
    begin
      s_d.ana       = 1'b1;
      s_d.ana_code  = `PIL_CODE_TRACE;
      s_d.trace_cnt = 8'h00;
    end
    else if (monitor_mode_i && instr_done_i)
    begin
      s_d.ana      = 1'b1;
      s_d.ana_code = `PIL_CODE_MONITOR;
    end
    if (take_v[1])
    begin
      s_d.svc = 1'b0;
    end
    if (svc_i)
    begin
      s_d.svc      = 1'b1;
      s_d.svc_code = svc_imm_i;
    end
    s_d.instruction_length_code = (svc_i || (s_q.svc && !take_v[1])) ? `PIL_ILC_SVC
                                                 : `PIL_ILC_ZERO;
    if (take_v[2])
    begin
      s_d.ext_p    = 1'b0;
      s_d.ext_code = 8'h00;
    end
    if (|ext_req_i)
    begin
      s_d.ext_p    = 1'b1;
      s_d.ext_code = (take_v[2] ? 8'h00 : s_q.ext_code) | ext_req_i;
    end
    if (take_v[3])
    begin
      s_d.tmr_p = 1'b0;
    end
    if (tmr_dec_to_zero_i || tmr_csw_i)
    begin
      s_d.tmr_p = 1'b1;
    end
    if (tmr_csw_i && |tmr_csw_data_i)
    begin
      s_d.csw_we = 1'b1;
      s_d.channel_status_word    = tmr_csw_data_i;
    end
    s_d.io_p = (s_q.io_p & ~io_take & ~io_relieve_i) | io_req_i;
    if (take_v[4])
    begin
      s_d.mchk = 1'b0;
    end
    unique case (s_q.stall)
      pil_idle:
      begin
        if (retrig)
        begin
          s_d.stall     = pil_run;
          s_d.stall_cnt = 32'h0;
        end
      end
      pil_run:
      begin
        if (retrig)
        begin
          s_d.stall_cnt = 32'h0;
        end
        else if (stopped_i || step_mode_i)
        begin
          s_d.stall_cnt = 32'h0;
        end
        else if (s_q.stall_cnt >= stall_lim)
        begin
          s_d.stall = pil_expired;
          s_d.mchk  = 1'b1;
        end
        else
        begin
          s_d.stall_cnt = s_q.stall_cnt + 32'h1;
        end
      end
      pil_expired:
      begin
        if (retrig)
        begin
          s_d.stall     = pil_run;
          s_d.stall_cnt = 32'h0;
        end
      end
    endcase
    if (wr && paddr == `PIL_OFS_PSWLO)
    begin
      s_d.program_status_word[31:0] = pwdata;
    end
    if (wr && paddr == `PIL_OFS_PSWHI)
    begin
      s_d.program_status_word[63:32] = pwdata;
    end
    if (rd)
    begin
      unique case (paddr)
        `PIL_OFS_PSWLO:   s_d.rdata = s_q.program_status_word[31:0];
        `PIL_OFS_PSWHI:   s_d.rdata = s_q.program_status_word[63:32];
        `PIL_OFS_PEND:    s_d.rdata = {s_q.io_p, 19'h0, s_q.mchk,
                                       s_q.tmr_p, s_q.ext_p, s_q.svc,
                                       s_q.ana};
        `PIL_OFS_EXTCODE: s_d.rdata = {24'h0, s_q.ext_code};
        `PIL_OFS_STATUS:  s_d.rdata = {22'h0, s_q.stall, s_q.trace_cnt};
        default:          s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q       <= '0;
      s_q.program_status_word   <= `PIL_RST_PSW;
      s_q.stall <= pil_idle;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < IO_LVLS; g++)
    begin : g_io
      assign io_req_o[g] = s_q.io_p[g] & s_q.program_status_word[`PIL_PSW_IO_LO + g]
                         & instr_done_i;
    end
  endgenerate

  assign prdata       = s_q.rdata;
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign prog_exc_o   = s_q.prog_exc;
  assign prog_code_o  = s_q.prog_code;
  assign ana_req_o    = s_q.ana & instr_done_i;
  assign ana_code_o   = s_q.ana_code;
  assign svc_req_o    = s_q.svc;
  assign svc_code_o   = s_q.svc_code;
  assign ilc_o        = s_q.instruction_length_code;
  assign ext_req_o    = s_q.ext_p & s_q.program_status_word[`PIL_PSW_EXT_BIT]
                      & instr_done_i;
  assign ext_code_o   = s_q.ext_code;
  assign tmr_req_o    = s_q.tmr_p & s_q.program_status_word[`PIL_PSW_TMR_BIT]
                      & instr_done_i;
  assign tmr_csw_we_o = s_q.csw_we;
  assign tmr_csw_o    = s_q.channel_status_word;
  assign io_csw_en_o  = iis_start_i & (|io_req_o);
  assign mchk_req_o   = s_q.mchk;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_signif_code: assert property (@(posedge pclk) disable iff (!presetn)
    fp_addsub_zero_i && s_q.program_status_word[39] && s_q.program_status_word[1] |=>
    prog_exc_o && {prog_code_o[7:5], prog_code_o[3:0]} == 7'h0e)
    else $error("significance code wrong");
  a_fpdiv_code: assert property (@(posedge pclk) disable iff (!presetn)
    fp_div_zero_i && !(fp_addsub_zero_i && s_q.program_status_word[39] && s_q.program_status_word[1])
    |=> {prog_code_o[7:5], prog_code_o[3:0]} == 7'h0f)
    else $error("divide code wrong");
  a_t_bit: assert property (@(posedge pclk) disable iff (!presetn)
    fp_div_zero_i |=> prog_code_o[4] == $past(instr_term_i))
    else $error("t bit wrong");
  a_svc_copy: assert property (@(posedge pclk) disable iff (!presetn)
    svc_i |=> svc_req_o && svc_code_o == $past(svc_imm_i)
    && ilc_o == 2'h1)
    else $error("svc code not copied");
  a_ext_merge: assert property (@(posedge pclk) disable iff (!presetn)
    !take_v[2] |=> (ext_code_o & $past(s_q.ext_code))
    == $past(s_q.ext_code))
    else $error("external merge lost bits");
  a_ext_mask: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.program_status_word[2] |-> !ext_req_o)
    else $error("external not masked");
  a_tmr_csw: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_csw_i && tmr_csw_data_i != 32'h0 |=> tmr_csw_we_o
    && tmr_csw_o == $past(tmr_csw_data_i))
    else $error("timer csw not written");
  a_stall_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    (stopped_i || step_mode_i) && !retrig && s_q.stall == pil_run
    |=> s_q.stall_cnt == 32'h0)
    else $error("stall not inhibited");
  a_io_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (io_req_o & ~s_q.program_status_word[11:4]) == 8'h00)
    else $error("io level not masked");
  c_ext_merge: cover property (@(posedge pclk) disable iff (!presetn)
    ext_req_i != 8'h00 ##[1:5] ext_req_i != 8'h00);
  c_mchk: cover property (@(posedge pclk) disable iff (!presetn)
    s_d.mchk && !s_q.mchk);
  c_trace: cover property (@(posedge pclk) disable iff (!presetn)
    ana_req_o && ana_code_o == 8'h01);

endmodule : pil_levels
`default_nettype wire

// ===== verification/pil_exec_model.sv
/*
  execution unit model: instruction start strobes and completion point.
  assumes the pclk and active-low presetn of the levels block.
*/
`timescale 1ns/1ps
`default_nettype none

module pil_exec_model #(
  parameter int unsigned CYC = 8
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic hold_done,
  output logic      instr_start,
  output logic      instr_done
);
  logic [7:0] cnt_q;
  // ----------------------------------------
  // instruction cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 8'h00;
    else if (run || cnt_q != 8'h00)
      cnt_q <= (cnt_q == CYC[7:0] - 8'h01) ? 8'h00 : cnt_q + 8'h01;
  assign instr_start = run && cnt_q == 8'h00;
  assign instr_done  = hold_done || cnt_q == CYC[7:0] - 8'h01;
endmodule : pil_exec_model

`default_nettype wire

// ===== verification/pil_levels_bench.sv
/*
  self-checking bench of the processor interrupt levels block.
  assumes a zero-wait apb slave and a 20-cycle stall count.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_fail++; $display("Error t=%0t got %h exp %h", $time, a, e); end end

module pil_levels_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, tmr_csw_data_i, tmr_csw_o;
  logic        fp_addsub_zero_i, fp_div_zero_i, ind_word_i, ind_start_i;
  logic [7:0]  ind_word_data_i, svc_imm_i, ext_req_i, io_req_i, io_relieve_i;
  logic        instr_term_i, trace_write_i, monitor_mode_i, svc_i;
  logic        tmr_dec_to_zero_i, tmr_csw_i, instr_start_i, instr_done_i;
  logic        iis_start_i, prog_exc_o, ana_req_o, svc_req_o, ext_req_o;
  logic [7:0]  prog_code_o, ana_code_o, svc_code_o, ext_code_o, io_req_o;
  logic [1:0]  ilc_o;
  logic        tmr_req_o, tmr_csw_we_o, io_csw_en_o, mchk_req_o;
  logic        run, hold_done;
  logic [4:0]  rt;
  logic [3:0]  lo4 [4];
  int          n_fail, samples_checked;

  pil_levels #(.STALL_CYC(20)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fp_addsub_zero_i, .fp_div_zero_i, .ind_word_i,
    .ind_word_data_i, .ind_start_i, .instr_term_i, .trace_write_i,
    .monitor_mode_i, .svc_i, .svc_imm_i, .ext_req_i, .tmr_dec_to_zero_i,
    .tmr_csw_i, .tmr_csw_data_i, .io_req_i, .io_relieve_i, .instr_start_i,
    .instr_done_i, .iis_start_i, .wait_i(rt[0]), .init_load_i(rt[1]),
    .emul_retrig_i(rt[2]), .stopped_i(rt[3]), .step_mode_i(rt[4]),
    .prog_exc_o, .prog_code_o, .ana_req_o, .ana_code_o, .svc_req_o,
    .svc_code_o, .ilc_o, .ext_req_o, .ext_code_o, .tmr_req_o, .tmr_csw_we_o,
    .tmr_csw_o, .io_req_o, .io_csw_en_o, .mchk_req_o
  );
  pil_exec_model model (
    .pclk, .presetn, .run, .hold_done,
    .instr_start(instr_start_i), .instr_done(instr_done_i)
  );

  // ----------------------------------------
  // clock, bus, closing and exception tasks, timeout
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
    #1;
  endtask : wr

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic exc(input int k);
    @(posedge pclk);
    fp_addsub_zero_i <= (k == 0);
    fp_div_zero_i    <= (k == 1);
    ind_start_i      <= (k > 1);
    @(posedge pclk);
    if (k > 1)
    begin
      ind_start_i     <= 1'b0;
      ind_word_i      <= 1'b1;
      ind_word_data_i <= (k == 2) ? 8'h20 : 8'h00;
      @(posedge pclk);
      if (k == 3)
      begin
        repeat (7) @(posedge pclk);
        #1 `CHK(prog_exc_o, 1'b0)
        @(posedge pclk);
      end
    end
    {fp_addsub_zero_i, fp_div_zero_i, ind_word_i} <= 3'h0;
    #1;
  endtask : exc

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, tmr_csw_data_i} = '0;
    {fp_addsub_zero_i, fp_div_zero_i, ind_word_i, ind_start_i} = '0;
    {ind_word_data_i, svc_imm_i, ext_req_i, io_req_i, io_relieve_i} = '0;
    {instr_term_i, trace_write_i, monitor_mode_i, svc_i, run, rt} = '0;
    {tmr_dec_to_zero_i, tmr_csw_i, iis_start_i} = '0;
    {n_fail, samples_checked} = '0;
    hold_done = 1'b1;
    presetn   = 1'b0;
    lo4       = '{4'he, 4'hf, 4'h5, 4'h6};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    svc_i     <= 1'b1;
    svc_imm_i <= 8'ha5;
    @(posedge pclk);
    svc_i <= 1'b0;
    #1 `CHK({svc_req_o, svc_code_o}, {1'b1, 8'ha5})
    `CHK(ilc_o, 2'h1)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rd[1], 1'b1)
    wr(12'h014, 32'h2);
    `CHK({svc_req_o, ilc_o}, 3'h0)
    $display("test svc done");
    exc(0);
    `CHK(prog_exc_o, 1'b0)
    wr(12'h000, 32'h2);
    exc(0);
    `CHK(prog_exc_o, 1'b0)
    wr(12'h004, 32'h80);
    for (int t = 0; t < 2; t++)
    begin
      instr_term_i <= t[0];
      for (int k = 0; k < 4; k++)
      begin
        exc(k);
        `CHK(prog_exc_o, 1'b1)
        `CHK(prog_code_o, {(k > 1) ? 3'h1 : 3'h0, t[0], lo4[k]})
      end
    end
    $display("test exceptions done");
    wr(12'h000, 32'h0);
    @(posedge pclk);
    ext_req_i <= 8'h80;
    @(posedge pclk);
    ext_req_i <= 8'h01;
    @(posedge pclk);
    ext_req_i <= 8'h00;
    #1 `CHK(ext_req_o, 1'b0)
    `CHK(ext_code_o, 8'h81)
    wr(12'h000, 32'h4);
    `CHK(ext_req_o, 1'b1)
    @(posedge pclk);
    hold_done <= 1'b0;
    #1 `CHK(ext_req_o, 1'b0)
    @(posedge pclk);
    hold_done <= 1'b1;
    wr(12'h014, 32'h4);
    `CHK({ext_req_o, ext_code_o}, 9'h0)
    $display("test external done");
    wr(12'h000, 32'h0);
    @(posedge pclk);
    tmr_csw_i      <= 1'b1;
    tmr_csw_data_i <= 32'h1234_5678;
    @(posedge pclk);
    tmr_csw_i <= 1'b0;
    #1 `CHK({tmr_csw_we_o, tmr_csw_o}, {1'b1, 32'h1234_5678})
    `CHK(tmr_req_o, 1'b0)
    @(posedge pclk);
    tmr_dec_to_zero_i <= 1'b1;
    @(posedge pclk);
    tmr_dec_to_zero_i <= 1'b0;
    wr(12'h000, 32'h8);
    `CHK(tmr_req_o, 1'b1)
    wr(12'h014, 32'h8);
    `CHK(tmr_req_o, 1'b0)
    $display("test timer done");
    @(posedge pclk);
    io_req_i <= 8'h81;
    @(posedge pclk);
    io_req_i <= 8'h00;
    wr(12'h000, 32'h10);
    `CHK(io_req_o, 8'h01)
    @(posedge pclk);
    iis_start_i <= 1'b1;
    #1 `CHK(io_csw_en_o, 1'b1)
    @(posedge pclk);
    iis_start_i  <= 1'b0;
    io_relieve_i <= 8'h01;
    @(posedge pclk);
    io_relieve_i <= 8'h00;
    wr(12'h000, 32'h810);
    `CHK(io_req_o, 8'h80)
    `CHK(io_csw_en_o, 1'b0)
    $display("test io done");
    @(posedge pclk);
    monitor_mode_i <= 1'b1;
    repeat (3) @(posedge pclk);
    monitor_mode_i <= 1'b0;
    #1 `CHK({ana_req_o, ana_code_o}, {1'b1, 8'h00})
    wr(12'h014, 32'h1);
    `CHK(ana_req_o, 1'b0)
    @(posedge pclk);
    trace_write_i <= 1'b1;
    repeat (127) @(posedge pclk);
    trace_write_i <= 1'b0;
    #1 `CHK(ana_req_o, 1'b0)
    @(posedge pclk);
    trace_write_i <= 1'b1;
    @(posedge pclk);
    trace_write_i <= 1'b0;
    #1 `CHK({ana_req_o, ana_code_o}, {1'b1, 8'h01})
    $display("test analysis done");
    @(posedge pclk);
    run <= 1'b1;
    wr(12'h014, 32'h10);
    repeat (60) @(posedge pclk);
    run <= 1'b0;
    #1 `CHK(mchk_req_o, 1'b0)
    repeat (30) @(posedge pclk);
    #1 `CHK(mchk_req_o, 1'b1)
    for (int j = 0; j < 5; j++)
    begin
      @(posedge pclk);
      run <= 1'b1;
      rt  <= 5'h01 << j;
      wr(12'h014, 32'h10);
      @(posedge pclk);
      run <= 1'b0;
      repeat (40) @(posedge pclk);
      #1;
      if (j < 3)
        `CHK(mchk_req_o, 1'b0)
      else
        `CHK(mchk_req_o, 1'b0)
      @(posedge pclk);
      rt <= 5'h00;
    end
    $display("test stall done");
    close_out();
  end
endmodule : pil_levels_bench

`default_nettype wire
